// >>> hdl/fhsc_pkg.sv
//------------------------------------------------------------------------------
// Floppy host status and control: shared constants and types
//------------------------------------------------------------------------------
// Holds the port offsets, field positions, reset values and cycle counts.
// Assumes a 50 MHz controller clock and 10-bit host I/O addresses.
//------------------------------------------------------------------------------
package fhsc_pkg;

    // Host port offsets
    localparam logic [9:0] SRA_ADDR = 10'h3F0;
    localparam logic [9:0] SRB_ADDR = 10'h3F1;
    localparam logic [9:0] DOR_ADDR = 10'h3F2;
    localparam logic [9:0] TDR_ADDR = 10'h3F3;
    localparam logic [9:0] DIR_ADDR = 10'h3F7;

    // Reset values and read enable patterns
    localparam logic [7:0] DOR_RESET  = 8'h00;
    localparam logic [1:0] TDR_RESET  = 2'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] OE_N_OFF   = 8'hFF;
    localparam logic [7:0] OE_N_ALL   = 8'h00;
    localparam logic [7:0] OE_N_TAPE  = 8'hFC;

    // Output control register fields
    localparam int DOR_SEL0 = 0;
    localparam int DOR_SEL1 = 1;
    localparam int DOR_SRST = 2;
    localparam int DOR_DMA  = 3;
    localparam int DOR_MOT0 = 4;
    localparam int DOR_MOT1 = 5;

    // Status A fields
    localparam int SRA_DIR  = 0;
    localparam int SRA_WP   = 1;
    localparam int SRA_IDX  = 2;
    localparam int SRA_HEAD = 3;
    localparam int SRA_TRK  = 4;
    localparam int SRA_STEP = 5;
    localparam int SRA_B6   = 6;
    localparam int SRA_IRQ  = 7;

    // Status B fields
    localparam int SRB_MOT0 = 0;
    localparam int SRB_MOT1 = 1;
    localparam int SRB_WG   = 2;
    localparam int SRB_RD   = 3;
    localparam int SRB_WD   = 4;
    localparam int SRB_B5   = 5;
    localparam int SRB_B6   = 6;
    localparam int SRB_B7   = 7;

    // Event latch channels; rising-edge channels are marked in the mask
    localparam int         EVT_N     = 4;
    localparam int         EVT_STEP  = 0;
    localparam int         EVT_WRITE_GATE_OUT = 1;
    localparam int         EVT_RDATA = 2;
    localparam int         EVT_WDATA = 3;
    localparam logic [3:0] EVT_RISE  = 4'h3;

    // Pin synchroniser lanes
    localparam int PIN_WP   = 0;
    localparam int PIN_IDX  = 1;
    localparam int PIN_TRK  = 2;
    localparam int PIN_RDAT = 3;

    // Soft reset stretch: least time rounds up to whole cycles
    localparam int         CLK_PERIOD_NS   = 20;
    localparam int         SOFT_RST_MIN_NS = 100;
    localparam int         SOFT_RST_CYC    =
        (SOFT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SOFT_RST_LOAD   = 3'(SOFT_RST_CYC);

    // Register layout mode
    typedef enum logic [2:0]
    {
        FHSC_MODE_BASE    = 3'b001,
        FHSC_MODE_EXT     = 3'b010,
        FHSC_MODE_COMPACT = 3'b100
    } fhsc_mode_t;

endpackage

// >>> hdl/fhsc_evt_if.sv
//------------------------------------------------------------------------------
// Event carrier between the register bank and the edge latch
//------------------------------------------------------------------------------
// Holds the monitored levels, per-channel clears and the latched results.
// Assumes both ends run on the controller clock.
`timescale 1ns/1ps
interface fhsc_evt_if;
    import fhsc_pkg::*;
    logic [EVT_N-1:0] lvl;
    logic [EVT_N-1:0] clr;
    logic [EVT_N-1:0] latch;
    logic [EVT_N-1:0] tog;

    modport bank  (output lvl, output clr, input  latch, input  tog);
    modport catch (input  lvl, input  clr, output latch, output tog);
endinterface

// >>> hdl/fhsc_event_latch.sv
//------------------------------------------------------------------------------
// Edge latch and toggle per monitored channel
//------------------------------------------------------------------------------
// Holds one sticky latch and one toggle per channel.
// Assumes levels come from the controller clock domain, already synchronised.
`timescale 1ns/1ps
module fhsc_event_latch
(
    input  wire logic    clk_in,
    input  wire logic    rst_in,
    input  wire logic    ce_in,
    fhsc_evt_if.catch    evt
);
    import fhsc_pkg::*;

    logic [EVT_N-1:0] prev_reg;
    logic [EVT_N-1:0] prev_next;
    logic [EVT_N-1:0] latch_reg;
    logic [EVT_N-1:0] latch_next;
    logic [EVT_N-1:0] tog_reg;
    logic [EVT_N-1:0] tog_next;
    logic [EVT_N-1:0] hit;

    //--------------------------------------------------------------------------
    // Per-channel edge detect
    //--------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < EVT_N; i++)
        begin : g_chan
            // Rise channels catch the active edge, the rest the inactive one
            assign hit[i] = EVT_RISE[i] ? (evt.lvl[i] & ~prev_reg[i])
                                        : (~evt.lvl[i] & prev_reg[i]);
        end
    endgenerate

    // A hit in the clearing cycle wins, so no edge is lost to a read
    always_comb
    begin
        prev_next  = evt.lvl;
        latch_next = hit | (latch_reg & ~evt.clr);
        tog_next   = tog_reg ^ hit;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prev_reg  <= '0;
            latch_reg <= '0;
            tog_reg   <= '0;
        end
        else if (ce_in)
        begin
            prev_reg  <= prev_next;
            latch_reg <= latch_next;
            tog_reg   <= tog_next;
        end
    end

    assign evt.latch = latch_reg;
    assign evt.tog   = tog_reg;

endmodule

// >>> hdl/fhsc_top.sv
//------------------------------------------------------------------------------
// Floppy host status and control register bank
//------------------------------------------------------------------------------
// Holds status A/B, output control and tape assign registers plus drive decode.
// Assumes host strobes are one-cycle pulses on CLOCK_IN; drive pins are async.
`timescale 1ns/1ps
module fhsc_top
(
    input  wire logic                CLOCK_IN,
    input  wire logic                SYS_RST_IN,
    input  wire logic                CLK_EN_IN,
    input  wire fhsc_pkg::fhsc_mode_t MODE_IN,
    input  wire logic [9:0]          HOST_ADDR_IN,
    input  wire logic                HOST_RD_IN,
    input  wire logic                HOST_WR_IN,
    input  wire logic [7:0]          HOST_DATA_IN,
    output      logic [7:0]          HOST_DATA_OUT,
    output      logic [7:0]          HOST_DATA_OE_N_OUT,
    input  wire logic                STEP_IN,
    input  wire logic                WRITE_GATE_IN,
    input  wire logic                WRITE_DATA_IN,
    input  wire logic                HEAD_SIDE_SELECT_IN,
    input  wire logic                HEAD_DIRECTION_IN,
    input  wire logic                FLOPPY_IRQ_IN,
    input  wire logic                DMA_REQUEST_IN,
    input  wire logic                WRITE_PROTECT_PIN_IN,
    input  wire logic                INDEX_PULSE_IN,
    input  wire logic                TRACK_ZERO_IN,
    input  wire logic                READ_DATA_PIN_IN,
    output      logic                DRIVE_SELECT_ZERO_LOW_OUT,
    output      logic                DRIVE_SELECT_ONE_LOW_OUT,
    output      logic                MOTOR_ZERO_LOW_OUT,
    output      logic                MOTOR_ONE_LOW_OUT,
    output      logic                SOFT_RESET_OUT,
    output      logic                DMA_GATE_OUT,
    output      logic                DMA_REQUEST_OUT,
    output      logic                DMA_REQUEST_OE_N_OUT,
    output      logic                FLOPPY_IRQ_OUT
);
    import fhsc_pkg::*;

    //--------------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------------
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic [7:0] dor_reg;
    logic [7:0] dor_next;
    logic [1:0] tdr_reg;
    logic [1:0] tdr_next;
    logic [2:0] srst_cnt_reg;
    logic [2:0] srst_cnt_next;
    logic [7:0] dout_reg;
    logic [7:0] dout_next;
    logic [7:0] oe_n_reg;
    logic [7:0] oe_n_next;
    logic       ds0_n_reg;
    logic       ds0_n_next;
    logic       ds1_n_reg;
    logic       ds1_n_next;
    logic       mot0_n_reg;
    logic       mot0_n_next;
    logic       mot1_n_reg;
    logic       mot1_n_next;
    logic       srst_reg;
    logic       srst_next;
    logic       gate_reg;
    logic       gate_next;
    logic       drq_reg;
    logic       drq_next;
    logic       drq_oe_n_reg;
    logic       drq_oe_n_next;
    logic       irq_reg;
    logic       irq_next;
    logic [7:0] drive_status_a_compact;
    logic [7:0] drive_status_b_extended;
    logic       dir_read;
    logic       sel0_hit;
    logic       sel1_hit;

    fhsc_evt_if evt ();

    //--------------------------------------------------------------------------
    // Drive pin synchronisers
    //--------------------------------------------------------------------------
    // Two stages; only the second stage is read by any logic
    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end
        else if (CLK_EN_IN)
        begin
            pin_meta_reg <= {READ_DATA_PIN_IN, TRACK_ZERO_IN,
                             INDEX_PULSE_IN, WRITE_PROTECT_PIN_IN};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    //--------------------------------------------------------------------------
    // Event latches for step, write gate and data edges
    //--------------------------------------------------------------------------
    // Input register read clears all latches; step also clears on soft reset
    assign dir_read              = HOST_RD_IN && (HOST_ADDR_IN == DIR_ADDR);
    assign evt.lvl[EVT_STEP]     = STEP_IN;
    assign evt.lvl[EVT_WRITE_GATE_OUT]    = WRITE_GATE_IN;
    assign evt.lvl[EVT_RDATA]    = pin_sync_reg[PIN_RDAT];
    assign evt.lvl[EVT_WDATA]    = WRITE_DATA_IN;
    assign evt.clr[EVT_STEP]     = dir_read | srst_reg;
    assign evt.clr[EVT_WRITE_GATE_OUT]    = dir_read;
    assign evt.clr[EVT_RDATA]    = dir_read;
    assign evt.clr[EVT_WDATA]    = dir_read;

    fhsc_event_latch u_latch
    (
        .clk_in (CLOCK_IN),
        .rst_in (SYS_RST_IN),
        .ce_in  (CLK_EN_IN),
        .evt    (evt)
    );

    //--------------------------------------------------------------------------
    // Status layouts
    //--------------------------------------------------------------------------
    // Mode input picks the layout; baseline never drives these ports
    always_comb
    begin
        drive_status_a_compact = 8'h00;
        drive_status_b_extended = 8'h00;
        if (MODE_IN == FHSC_MODE_COMPACT)
        begin
            drive_status_a_compact[SRA_DIR]  = ~HEAD_DIRECTION_IN;
            drive_status_a_compact[SRA_WP]   = pin_sync_reg[PIN_WP];
            drive_status_a_compact[SRA_IDX]  = pin_sync_reg[PIN_IDX];
            drive_status_a_compact[SRA_HEAD] = ~HEAD_SIDE_SELECT_IN;
            drive_status_a_compact[SRA_TRK]  = pin_sync_reg[PIN_TRK];
            drive_status_a_compact[SRA_STEP] = evt.latch[EVT_STEP];
            drive_status_a_compact[SRA_B6]   = drq_reg;
            drive_status_a_compact[SRA_IRQ]  = FLOPPY_IRQ_IN;
            drive_status_b_extended[SRB_MOT0] = 1'b1;
            drive_status_b_extended[SRB_MOT1] = 1'b1;
            drive_status_b_extended[SRB_WG]   = evt.latch[EVT_WRITE_GATE_OUT];
            drive_status_b_extended[SRB_RD]   = evt.latch[EVT_RDATA];
            drive_status_b_extended[SRB_WD]   = evt.latch[EVT_WDATA];
            drive_status_b_extended[SRB_B5]   = ds0_n_reg;
            drive_status_b_extended[SRB_B6]   = ds1_n_reg;
            drive_status_b_extended[SRB_B7]   = 1'b1;   // Second-drive input is unsupported
        end
        else
        begin
            drive_status_a_compact[SRA_DIR]  = HEAD_DIRECTION_IN;
            drive_status_a_compact[SRA_WP]   = ~pin_sync_reg[PIN_WP];
            drive_status_a_compact[SRA_IDX]  = ~pin_sync_reg[PIN_IDX];
            drive_status_a_compact[SRA_HEAD] = HEAD_SIDE_SELECT_IN;
            drive_status_a_compact[SRA_TRK]  = ~pin_sync_reg[PIN_TRK];
            drive_status_a_compact[SRA_STEP] = STEP_IN;
            drive_status_a_compact[SRA_B6]   = 1'b1;
            drive_status_a_compact[SRA_IRQ]  = FLOPPY_IRQ_IN;
            drive_status_b_extended[SRB_MOT0] = dor_reg[DOR_MOT0];
            drive_status_b_extended[SRB_MOT1] = dor_reg[DOR_MOT1];
            drive_status_b_extended[SRB_WG]   = WRITE_GATE_IN;
            drive_status_b_extended[SRB_RD]   = evt.tog[EVT_RDATA];
            drive_status_b_extended[SRB_WD]   = evt.tog[EVT_WDATA];
            drive_status_b_extended[SRB_B5]   = dor_reg[DOR_SEL0];
            drive_status_b_extended[SRB_B6]   = 1'b1;
            drive_status_b_extended[SRB_B7]   = 1'b1;
        end
    end

    //--------------------------------------------------------------------------
    // Register bank, read port and drive outputs
    //--------------------------------------------------------------------------
    assign sel0_hit = (dor_reg[DOR_SEL1:DOR_SEL0] == 2'b00) && dor_reg[DOR_MOT0];
    assign sel1_hit = (dor_reg[DOR_SEL1:DOR_SEL0] == 2'b01) && dor_reg[DOR_MOT1];

    // Next values; soft reset never touches output or tape registers
    always_comb
    begin
        dor_next  = dor_reg;
        tdr_next  = tdr_reg;
        dout_next = dout_reg;
        oe_n_next = OE_N_OFF;
        if (HOST_WR_IN && (HOST_ADDR_IN == DOR_ADDR))
        begin
            dor_next = HOST_DATA_IN;
        end
        if (HOST_WR_IN && (HOST_ADDR_IN == TDR_ADDR))
        begin
            tdr_next = HOST_DATA_IN[1:0];
        end
        if (HOST_RD_IN)
        begin
            case (HOST_ADDR_IN)
                SRA_ADDR:
                begin
                    if (MODE_IN != FHSC_MODE_BASE)
                    begin
                        dout_next = drive_status_a_compact;
                        oe_n_next = OE_N_ALL;
                    end
                end
                SRB_ADDR:
                begin
                    if (MODE_IN != FHSC_MODE_BASE)
                    begin
                        dout_next = drive_status_b_extended;
                        oe_n_next = OE_N_ALL;
                    end
                end
                DOR_ADDR:
                begin
                    dout_next = dor_reg;
                    oe_n_next = OE_N_ALL;
                end
                TDR_ADDR:
                begin
                    dout_next = {6'h00, tdr_reg};
                    oe_n_next = OE_N_TAPE;
                end
                default: oe_n_next = OE_N_OFF;
            endcase
        end
        // Stretch soft reset so back-to-back bit toggles still meet the minimum
        srst_cnt_next = 3'h0;
        if (!dor_reg[DOR_SRST])
        begin
            srst_cnt_next = SOFT_RST_LOAD;
        end
        else if (srst_cnt_reg != 3'h0)
        begin
            srst_cnt_next = srst_cnt_reg - 3'h1;
        end
        srst_next   = !dor_reg[DOR_SRST] || (srst_cnt_reg != 3'h0);
        // Extended mode keeps DMA and interrupt live, even in soft reset
        gate_next   = (MODE_IN == FHSC_MODE_EXT) || dor_reg[DOR_DMA];
        drq_next    = DMA_REQUEST_IN && gate_next;
        drq_oe_n_next = !gate_next;   // Request floats when gated off
        irq_next    = FLOPPY_IRQ_IN && gate_next;
        ds0_n_next  = !sel0_hit;
        ds1_n_next  = !sel1_hit;
        mot0_n_next = !dor_reg[DOR_MOT0];
        mot1_n_next = !dor_reg[DOR_MOT1];
    end

    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            dor_reg      <= DOR_RESET;
            tdr_reg      <= TDR_RESET;
            srst_cnt_reg <= SOFT_RST_LOAD;
            dout_reg     <= DATA_RESET;
            oe_n_reg     <= OE_N_OFF;
            srst_reg     <= 1'b1;
            gate_reg     <= 1'b0;
            drq_reg      <= 1'b0;
            drq_oe_n_reg <= 1'b1;
            irq_reg      <= 1'b0;
            ds0_n_reg    <= 1'b1;
            ds1_n_reg    <= 1'b1;
            mot0_n_reg   <= 1'b1;
            mot1_n_reg   <= 1'b1;
        end
        else if (CLK_EN_IN)
        begin
            dor_reg      <= dor_next;
            tdr_reg      <= tdr_next;
            srst_cnt_reg <= srst_cnt_next;
            dout_reg     <= dout_next;
            oe_n_reg     <= oe_n_next;
            srst_reg     <= srst_next;
            gate_reg     <= gate_next;
            drq_reg      <= drq_next;
            drq_oe_n_reg <= drq_oe_n_next;
            irq_reg      <= irq_next;
            ds0_n_reg    <= ds0_n_next;
            ds1_n_reg    <= ds1_n_next;
            mot0_n_reg   <= mot0_n_next;
            mot1_n_reg   <= mot1_n_next;
        end
    end

    assign HOST_DATA_OUT             = dout_reg;
    assign HOST_DATA_OE_N_OUT        = oe_n_reg;
    assign SOFT_RESET_OUT            = srst_reg;
    assign DMA_GATE_OUT              = gate_reg;
    assign DMA_REQUEST_OUT           = drq_reg;
    assign DMA_REQUEST_OE_N_OUT      = drq_oe_n_reg;
    assign FLOPPY_IRQ_OUT            = irq_reg;
    assign DRIVE_SELECT_ZERO_LOW_OUT = ds0_n_reg;
    assign DRIVE_SELECT_ONE_LOW_OUT  = ds1_n_reg;
    assign MOTOR_ZERO_LOW_OUT        = mot0_n_reg;
    assign MOTOR_ONE_LOW_OUT         = mot1_n_reg;

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);

    chk_sra_ext_fixed: assert property (
        CLK_EN_IN && HOST_RD_IN && HOST_ADDR_IN == SRA_ADDR && MODE_IN == FHSC_MODE_EXT
        |=> HOST_DATA_OUT[SRA_B6] && HOST_DATA_OUT[SRA_IRQ] == $past(FLOPPY_IRQ_IN))
        else $error("status A extended bits wrong");
    chk_sra_compact_dir: assert property (
        CLK_EN_IN && HOST_RD_IN && HOST_ADDR_IN == SRA_ADDR && MODE_IN == FHSC_MODE_COMPACT
        |=> HOST_DATA_OUT[SRA_DIR] != $past(HEAD_DIRECTION_IN))
        else $error("compact direction not inverted");
    chk_srb_base_float: assert property (
        CLK_EN_IN && HOST_RD_IN && HOST_ADDR_IN == SRB_ADDR && MODE_IN == FHSC_MODE_BASE
        |=> HOST_DATA_OE_N_OUT == OE_N_OFF)
        else $error("baseline status B read drove bus");
    chk_srb_ext_upper: assert property (
        CLK_EN_IN && HOST_RD_IN && HOST_ADDR_IN == SRB_ADDR && MODE_IN == FHSC_MODE_EXT
        |=> HOST_DATA_OUT[SRB_B7:SRB_B6] == 2'b11 && HOST_DATA_OE_N_OUT == OE_N_ALL)
        else $error("status B reserved bits not one");
    chk_tape_upper_float: assert property (
        CLK_EN_IN && HOST_RD_IN && HOST_ADDR_IN == TDR_ADDR
        |=> HOST_DATA_OE_N_OUT == OE_N_TAPE)
        else $error("tape register upper bits driven");
    chk_select_decode: assert property (
        CLK_EN_IN |=> DRIVE_SELECT_ZERO_LOW_OUT == !$past(sel0_hit)
                   && DRIVE_SELECT_ONE_LOW_OUT == !$past(sel1_hit))
        else $error("drive select decode wrong");
    chk_ext_dma_live: assert property (
        CLK_EN_IN && MODE_IN == FHSC_MODE_EXT |=> !DMA_REQUEST_OE_N_OUT)
        else $error("extended mode gated DMA request");
    chk_soft_reset_hold: assert property (
        CLK_EN_IN && $rose(dor_reg[DOR_SRST]) |-> SOFT_RESET_OUT[*4])
        else $error("soft reset released too early");
    chk_output_write: assert property (
        CLK_EN_IN && HOST_WR_IN && HOST_ADDR_IN == DOR_ADDR
        |=> dor_reg == $past(HOST_DATA_IN))
        else $error("output register write lost");

    cov_drive0_on: cover property (CLK_EN_IN && !DRIVE_SELECT_ZERO_LOW_OUT && !MOTOR_ZERO_LOW_OUT);
    cov_step_cleared: cover property (evt.latch[EVT_STEP] && dir_read);
    cov_soft_reset: cover property ($fell(SOFT_RESET_OUT));

endmodule

// >>> dv/fhsc_drive_model.sv
// Drive stand-in: write protect, index, track zero and read data pins.
// Assumes the bench clock; the block treats these pins as async.
`timescale 1ns/1ps
module fhsc_drive_model
(
    input  wire logic CLK_IN,
    input  wire logic SEL_LOW_IN,
    output      logic WP_OUT = 1'b0,
    output      logic IDX_OUT = 1'b0,
    output      logic TRK_OUT = 1'b0,
    output      logic RDAT_OUT = 1'b0
);
    logic [1:0] ph_reg = 2'h0;
    // Deselected drive drops every line to the inactive level
    always @(posedge CLK_IN)
    begin
        ph_reg <= ph_reg + 2'h1;
        WP_OUT <= !SEL_LOW_IN;
        IDX_OUT <= !SEL_LOW_IN && ph_reg == 2'h0;
        TRK_OUT <= !SEL_LOW_IN;
        RDAT_OUT <= !SEL_LOW_IN && ph_reg[1];
    end
endmodule

// >>> dv/fhsc_top_test.sv
// Self-checking bench for the floppy host status and control bank.
// Assumes the drive model is compiled before this file.
`timescale 1ns/1ps
module fhsc_top_test;
    import fhsc_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    fhsc_mode_t mode = FHSC_MODE_EXT;
    logic [9:0] addr = 10'h0;
    logic       rd = 1'b0;
    logic       wr = 1'b0;
    logic [7:0] wdat = 8'h00;
    logic [6:0] core = 7'h00;
    logic [7:0] dout, oen, got, goe;
    logic [3:0] pins;
    logic       srst, gate, drq, drq_oen, irq, wp, idx, trk, rdat;
    int         errors = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    always #10 clk = ~clk;
    fhsc_drive_model u_fhsc_drive_model
    (.CLK_IN(clk), .SEL_LOW_IN(pins[2]), .WP_OUT(wp), .IDX_OUT(idx), .TRK_OUT(trk),
     .RDAT_OUT(rdat));
    fhsc_top u_fhsc_top
    (.CLOCK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(1'b1), .MODE_IN(mode),
     .HOST_ADDR_IN(addr), .HOST_RD_IN(rd), .HOST_WR_IN(wr), .HOST_DATA_IN(wdat),
     .HOST_DATA_OUT(dout), .HOST_DATA_OE_N_OUT(oen), .STEP_IN(core[0]),
     .WRITE_GATE_IN(core[1]), .WRITE_DATA_IN(core[2]), .HEAD_SIDE_SELECT_IN(core[3]),
     .HEAD_DIRECTION_IN(core[4]), .FLOPPY_IRQ_IN(core[5]), .DMA_REQUEST_IN(core[6]),
     .WRITE_PROTECT_PIN_IN(wp), .INDEX_PULSE_IN(idx), .TRACK_ZERO_IN(trk),
     .READ_DATA_PIN_IN(rdat), .DRIVE_SELECT_ZERO_LOW_OUT(pins[2]),
     .DRIVE_SELECT_ONE_LOW_OUT(pins[3]), .MOTOR_ZERO_LOW_OUT(pins[0]),
     .MOTOR_ONE_LOW_OUT(pins[1]), .SOFT_RESET_OUT(srst), .DMA_GATE_OUT(gate),
     .DMA_REQUEST_OUT(drq), .DMA_REQUEST_OE_N_OUT(drq_oen), .FLOPPY_IRQ_OUT(irq));
    // Byte comparison shared by every scenario
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Host strobes last one cycle; settle time covers the registered outputs
    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk) {addr, wdat, wr} = {a, d, 1'b1};
        @(negedge clk) wr = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic rd_reg(input logic [9:0] a);
        @(negedge clk) {addr, rd} = {a, 1'b1};
        @(negedge clk) rd = 1'b0;
        // The bus is enabled only in the cycle after the taking edge; the data byte holds
        {got, goe} = {dout, oen};
        repeat (2) @(negedge clk);
    endtask
    task automatic t_ext();
        core = 7'h20;
        rd_reg(SRA_ADDR); chk("sra", 8'hC0, got & 8'hC0);
        chk("irq", 8'h01, {7'h0, irq});
        core = 7'h00;
        rd_reg(DOR_ADDR); chk("dor", 8'h00, got);
        rd_reg(SRB_ADDR); chk("srb", 8'hC0, got);
        core[2] = 1'b1;
        @(negedge clk) core[2] = 1'b0;
        rd_reg(SRB_ADDR); chk("srb", 8'hD0, got);
        chk("gate", 8'h01, {7'h0, gate});
        chk("srst", 8'h01, {7'h0, srst});
        wr_reg(DOR_ADDR, 8'h1C); chk("pins", 8'h0A, {4'h0, pins});
        repeat (6) @(negedge clk); chk("srst", 8'h00, {7'h0, srst});
        rd_reg(SRB_ADDR); chk("srb", 8'hC1, got & 8'hE7);
        wr_reg(DOR_ADDR, 8'h2D); chk("pins", 8'h05, {4'h0, pins});
        rd_reg(SRB_ADDR); chk("srb", 8'hE2, got & 8'hE7);
        wr_reg(DOR_ADDR, 8'hC9); chk("pins", 8'h0F, {4'h0, pins});
        rd_reg(DOR_ADDR); chk("dor", 8'hC9, got);
        chk("srst", 8'h01, {7'h0, srst});
    endtask
    task automatic t_base();
        mode = FHSC_MODE_BASE;
        core = 7'h60;
        rd_reg(SRB_ADDR); chk("srb_oe", 8'hFF, goe);
        wr_reg(DOR_ADDR, 8'h04); chk("drq_oe", 8'h01, {7'h0, drq_oen});
        chk("irq", 8'h00, {7'h0, irq});
        wr_reg(DOR_ADDR, 8'h0C); chk("drq", 8'h01, {drq_oen, 6'h0, drq});
        chk("irq", 8'h01, {7'h0, irq});
        wr_reg(TDR_ADDR, 8'hFE); rd_reg(TDR_ADDR); chk("tdr_oe", 8'hFC, goe);
        chk("tdr", 8'h02, got & 8'h03);
    endtask
    task automatic t_compact();
        mode = FHSC_MODE_COMPACT;
        core = 7'h11;
        @(negedge clk) core = 7'h12;
        @(negedge clk) core = 7'h10;
        rd_reg(SRA_ADDR); chk("sra", 8'h28, got & 8'h29);
        rd_reg(SRB_ADDR); chk("srb", 8'h04, got & 8'h04);
        core = 7'h70;
        rd_reg(DIR_ADDR); rd_reg(SRA_ADDR); chk("sra", 8'hC8, got & 8'hE9);
        rd_reg(SRB_ADDR); chk("srb", 8'h00, got & 8'h04);
        chk("srb", 8'hE3, got);
        wr_reg(DOR_ADDR, 8'h1C);
        core = 7'h04;
        @(negedge clk) core = 7'h00;
        repeat (8) @(negedge clk);
        rd_reg(SRB_ADDR); chk("srb", 8'h5B, got & 8'h7B);
        core = 7'h11;
        @(negedge clk) core = 7'h10;
        rd_reg(SRA_ADDR); chk("sra", 8'h20, got & 8'h20);
        wr_reg(DOR_ADDR, 8'h18);
        rd_reg(SRA_ADDR); chk("sra", 8'h00, got & 8'h20);
    endtask
    // Soft reset keeps registers; a mid-run hardware reset clears them
    task automatic t_reset();
        mode = FHSC_MODE_EXT;
        wr_reg(TDR_ADDR, 8'h03);
        wr_reg(DOR_ADDR, 8'h31);
        rd_reg(SRB_ADDR); chk("srb", 8'hE3, got & 8'hE7);
        rd_reg(TDR_ADDR); chk("tdr", 8'h03, got & 8'h03);
        @(negedge clk) rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd_reg(SRB_ADDR); chk("srb", 8'hC0, got);
        rd_reg(DOR_ADDR); chk("dor", 8'h00, got);
        chk("gate", 8'h01, {7'h0, gate});
        rd_reg(TDR_ADDR); chk("tdr", 8'h00, got & 8'h03);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_ext(); t_base(); t_compact(); t_reset();
        final_report();
    end
    // A hang stops the run at the closing report
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            final_report();
        end
    end
endmodule
